// [perf_counter_pkg.sv]
// Package of constants and types for the dual event performance counters
package perf_counter_pkg;

    localparam int COUNT_WIDTH = 40;
    localparam int SETUP_WIDTH = 32;

    // Setup register field positions; the last two are the counter-read gate bit and the sign bit
    localparam int EVENT_SELECT_LSB = 0;
    localparam int EVENT_QUALIFIER_LSB = 8;
    localparam int USER_LEVEL_QUALIFIER_BIT = 16;
    localparam int SUPERVISOR_QUALIFIER_BIT = 17;
    localparam int EDGE_DETECT_BIT = 18;
    localparam int PIN_SIGNALLING_BIT = 19;
    localparam int INTERRUPT_ENABLE_BIT = 20;
    localparam int GLOBAL_ENABLE_BIT = 22;
    localparam int THRESHOLD_INVERT_BIT = 23;
    localparam int PER_CYCLE_THRESHOLD_LSB = 24;
    localparam int COUNTER_READ_GATE_BIT = 8;
    localparam int SIGN_BIT = 31;

    // Reset values
    localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
    localparam logic [39:0] COUNT_RESET = 40'h00_0000_0000;

    // Register selection codes on the register access port
    localparam logic [1:0] SEL_SETUP_ZERO = 2'h0;
    localparam logic [1:0] SEL_SETUP_ONE = 2'h1;
    localparam logic [1:0] SEL_COUNT_ZERO = 2'h2;
    localparam logic [1:0] SEL_COUNT_ONE = 2'h3;

    // Width of the per-cycle event count from each detection unit
    localparam int EVENT_COUNT_WIDTH = 4;

    // Bus clock is the processor clock divided by this ratio
    localparam int BUS_CLOCK_RATIO = 2;

    typedef struct packed {
        logic [7:0] per_cycle_threshold;
        logic threshold_invert;
        logic global_enable;
        logic reserved_21;
        logic interrupt_enable;
        logic pin_signalling;
        logic edge_detect;
        logic supervisor_qualifier;
        logic user_level_qualifier;
        logic [7:0] event_qualifier;
        logic [7:0] event_select;
    } event_setup_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] select;
        logic [31:0] wdata;
    } reg_request_type;

endpackage

// [perf_event_unit.sv]
// One performance counter with its event qualification and monitor pin logic
`timescale 1ns/1ps

module perf_event_unit #(
    parameter int COUNT_WIDTH = 40,
    parameter int EVENT_COUNT_WIDTH = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Setup and qualification
    input wire perf_counter_pkg::event_setup_type setup_i,
    input wire logic active_i,
    input wire logic privilege_zero_i,
    input wire logic [EVENT_COUNT_WIDTH-1:0] events_i,
    input wire logic bus_edge_i,
    // Counter write
    input wire logic load_i,
    input wire logic [31:0] load_data_i,
    // Results
    output logic [COUNT_WIDTH-1:0] count_o,
    output logic overflow_o,
    output logic monitor_pin_o
);

    logic [7:0] raw_sum;
    logic priv_ok;
    logic cond_now;
    logic cond_prev_reg;
    logic [7:0] step;
    logic [COUNT_WIDTH:0] sum_wide;
    logic pin_request_reg;
    logic increment;

    always_comb begin
        raw_sum = 8'(events_i);
        priv_ok = (setup_i.user_level_qualifier && !privilege_zero_i)
            || (setup_i.supervisor_qualifier && privilege_zero_i);
        if (setup_i.per_cycle_threshold == 8'h00) begin
            cond_now = (raw_sum != 8'h00);
        end else if (setup_i.threshold_invert) begin
            cond_now = (raw_sum < setup_i.per_cycle_threshold);
        end else begin
            cond_now = (raw_sum >= setup_i.per_cycle_threshold);
        end
        cond_now = cond_now && priv_ok && active_i;
        if (!cond_now) begin
            step = 8'h00;
        end else if (setup_i.edge_detect) begin
            step = cond_prev_reg ? 8'h00 : 8'h01;
        end else if (setup_i.per_cycle_threshold == 8'h00) begin
            step = raw_sum;
        end else begin
            step = 8'h01;
        end
        increment = (step != 8'h00);
        sum_wide = {1'b0, count_o} + {{(COUNT_WIDTH-7){1'b0}}, step};
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cond_prev_reg <= 1'b0;
        end else begin
            cond_prev_reg <= cond_now;
        end
    end

    // Counter with sign-extending load and carry-out overflow
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_o <= '0;
            overflow_o <= 1'b0;
        end else if (load_i) begin
            count_o <= {{(COUNT_WIDTH-32){load_data_i[31]}}, load_data_i};
            overflow_o <= 1'b0;
        end else begin
            count_o <= sum_wide[COUNT_WIDTH-1:0];
            overflow_o <= sum_wide[COUNT_WIDTH];
        end
    end

    // Monitor pin: one bus clock high, then at least one low, so steady requests still toggle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_request_reg <= 1'b0;
            monitor_pin_o <= 1'b0;
        end else begin
            if ((setup_i.pin_signalling && increment) || (!setup_i.pin_signalling && overflow_o)) begin
                pin_request_reg <= 1'b1;
            end else if (bus_edge_i && !monitor_pin_o) begin
                pin_request_reg <= 1'b0;
            end
            if (bus_edge_i) begin
                monitor_pin_o <= pin_request_reg && !monitor_pin_o;
            end
        end
    end

endmodule // perf_event_unit

// [dual_event_perf_counters.sv]
// Top of the dual event performance counters with register access port
//
// Behaviour
// - Two independent 40-bit counters count events or measure durations.
// - Duration mode adds one per processor clock while the condition holds.
// - Setup bits 7:0 select the event detection unit feeding the counter.
// - Setup bits 15:8 qualify the selected unit to one condition.
// - Bit 16 counts at privilege levels 1, 2 or 3.
// - Bit 17 counts at privilege level 0.
// - Bit 18 counts only rising transitions of the qualified condition.
// - Bit 19 toggles the monitor pin per increment, otherwise on overflow.
// - A pin toggle is high for exactly one bus clock.
// - Bit 20 raises an interrupt request on counter overflow.
// - Bit 22 of first setup register enables or disables both counters.
// - Nonzero threshold: add one when per-cycle count reaches threshold.
// - Bit 23 inverts the threshold test to less-than; ignored at zero threshold.
// - Zero threshold adds the full per-cycle event count.
// - Register access works only at privilege level 0.
// - Counter-read instruction restricted to level 0 when the read gate is set.
// - Counter-read instruction does not serialize with other instructions.
// - Counter writes store low 32 bits and sign-extend bit 31 above.
// - Counting begins after the write that sets the global enable.
// - Global clear or clearing both setups stops; clearing second stops only it.
`timescale 1ns/1ps

module dual_event_perf_counters #(
    parameter int COUNT_WIDTH = 40,
    parameter int EVENT_COUNT_WIDTH = 4,
    parameter int UNIT_COUNT = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Processor state
    input wire logic privilege_zero_i,
    input wire logic counter_read_gate_i,
    // Event detection units, one per-cycle count per unit
    input wire logic [UNIT_COUNT*EVENT_COUNT_WIDTH-1:0] unit_events_i,
    input wire logic [7:0] unit_qualifier_i,
    // Privileged register access
    input wire perf_counter_pkg::reg_request_type reg_req_i,
    output logic [COUNT_WIDTH-1:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_fault_o,
    // Counter-read instruction
    input wire logic counter_read_i,
    input wire logic counter_read_sel_i,
    output logic [COUNT_WIDTH-1:0] counter_read_data_o,
    output logic counter_read_ack_o,
    output logic counter_read_fault_o,
    // Monitor pins and interrupt request
    output logic [1:0] monitor_pin_o,
    output logic overflow_irq_o
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    perf_counter_pkg::event_setup_type setup_reg [2];
    logic [COUNT_WIDTH-1:0] count [2];
    logic [1:0] overflow;
    logic [1:0] load;
    logic [1:0] active;
    logic [EVENT_COUNT_WIDTH-1:0] events [2];
    logic [1:0] bus_div_reg;
    logic bus_edge;
    logic reg_ok;
    logic [1:0] pin_unused;

    // Selected unit events, gated by the qualifier match
    function automatic logic [EVENT_COUNT_WIDTH-1:0] pick_events(
        input perf_counter_pkg::event_setup_type s,
        input logic [UNIT_COUNT*EVENT_COUNT_WIDTH-1:0] units,
        input logic [7:0] qual
    );
        logic [EVENT_COUNT_WIDTH-1:0] r;
        r = '0;
        for (int u = 0; u < UNIT_COUNT; u++) begin
            if (s.event_select == 8'(u)) begin
                r = units[u*EVENT_COUNT_WIDTH +: EVENT_COUNT_WIDTH];
            end
        end
        if ((s.event_qualifier != 8'h00) && ((s.event_qualifier & qual) == 8'h00)) begin
            r = '0;
        end
        return r;
    endfunction

    always_comb begin
        reg_ok = reg_req_i.valid && privilege_zero_i;
        load[0] = reg_ok && reg_req_i.write && (reg_req_i.select == perf_counter_pkg::SEL_COUNT_ZERO);
        load[1] = reg_ok && reg_req_i.write && (reg_req_i.select == perf_counter_pkg::SEL_COUNT_ONE);
        // A counter with an all-zero setup counts nothing, so clearing setups stops it
        active[0] = setup_reg[0].global_enable && (setup_reg[0] != '0);
        active[1] = setup_reg[0].global_enable && (setup_reg[1] != '0);
        events[0] = pick_events(setup_reg[0], unit_events_i, unit_qualifier_i);
        events[1] = pick_events(setup_reg[1], unit_events_i, unit_qualifier_i);
        bus_edge = (bus_div_reg == 2'(perf_counter_pkg::BUS_CLOCK_RATIO - 1));
    end

    // ------------------------------------------------------------
    // Setup register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            setup_reg[0] <= perf_counter_pkg::SETUP_RESET;
            setup_reg[1] <= perf_counter_pkg::SETUP_RESET;
        end else if (reg_ok && reg_req_i.write) begin
            // Enable takes effect from the cycle after the write
            if (reg_req_i.select == perf_counter_pkg::SEL_SETUP_ZERO) begin
                setup_reg[0] <= reg_req_i.wdata;
            end
            if (reg_req_i.select == perf_counter_pkg::SEL_SETUP_ONE) begin
                // Second setup has no global enable bit
                setup_reg[1] <= reg_req_i.wdata & ~(32'h1 << perf_counter_pkg::GLOBAL_ENABLE_BIT);
            end
        end
    end

    // ------------------------------------------------------------
    // Bus clock divider for pin timing
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_div_reg <= 2'h0;
        end else if (bus_edge) begin
            bus_div_reg <= 2'h0;
        end else begin
            bus_div_reg <= bus_div_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Counter units
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_unit
        perf_event_unit #(
            .COUNT_WIDTH(COUNT_WIDTH),
            .EVENT_COUNT_WIDTH(EVENT_COUNT_WIDTH)
        ) u_unit (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .setup_i(setup_reg[i]),
            .active_i(active[i]),
            .privilege_zero_i(privilege_zero_i),
            .events_i(events[i]),
            .bus_edge_i(bus_edge),
            .load_i(load[i]),
            .load_data_i(reg_req_i.wdata),
            .count_o(count[i]),
            .overflow_o(overflow[i]),
            .monitor_pin_o(pin_unused[i])
        );
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            monitor_pin_o <= 2'h0;
        end else begin
            monitor_pin_o <= pin_unused;
        end
    end

    // ------------------------------------------------------------
    // Overflow interrupt request
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            overflow_irq_o <= 1'b0;
        end else begin
            overflow_irq_o <= (overflow[0] && setup_reg[0].interrupt_enable)
                || (overflow[1] && setup_reg[1].interrupt_enable);
        end
    end

    // ------------------------------------------------------------
    // Privileged register read and write answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= '0;
            reg_ack_o <= 1'b0;
            reg_fault_o <= 1'b0;
        end else begin
            reg_ack_o <= reg_ok;
            reg_fault_o <= reg_req_i.valid && !privilege_zero_i;
            if (reg_ok && !reg_req_i.write) begin
                case (reg_req_i.select)
                    perf_counter_pkg::SEL_SETUP_ZERO: begin
                        reg_rdata_o <= {{(COUNT_WIDTH-32){1'b0}}, setup_reg[0]};
                    end
                    perf_counter_pkg::SEL_SETUP_ONE: begin
                        reg_rdata_o <= {{(COUNT_WIDTH-32){1'b0}}, setup_reg[1]};
                    end
                    perf_counter_pkg::SEL_COUNT_ZERO: begin
                        reg_rdata_o <= count[0];
                    end
                    default: begin
                        reg_rdata_o <= count[1];
                    end
                endcase
            end else begin
                reg_rdata_o <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Counter-read instruction: samples the counter at once, no ordering
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            counter_read_data_o <= '0;
            counter_read_ack_o <= 1'b0;
            counter_read_fault_o <= 1'b0;
        end else begin
            if (counter_read_i && (privilege_zero_i || !counter_read_gate_i)) begin
                counter_read_ack_o <= 1'b1;
                counter_read_fault_o <= 1'b0;
                counter_read_data_o <= count[counter_read_sel_i];
            end else begin
                counter_read_ack_o <= 1'b0;
                counter_read_fault_o <= counter_read_i;
                counter_read_data_o <= '0;
            end
        end
    end

endmodule // dual_event_perf_counters

// [dual_event_perf_counters_chk.sv]
// Assertion checker for the dual event performance counters
`timescale 1ns/1ps

module dual_event_perf_counters_chk #(
    parameter int COUNT_WIDTH = 40,
    parameter int EVENT_COUNT_WIDTH = 4,
    parameter int UNIT_COUNT = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Watched ports
    input wire logic privilege_zero_i,
    input wire logic counter_read_gate_i,
    input wire perf_counter_pkg::reg_request_type reg_req_i,
    input wire logic [COUNT_WIDTH-1:0] reg_rdata_o,
    input wire logic reg_ack_o,
    input wire logic reg_fault_o,
    input wire logic counter_read_i,
    input wire logic counter_read_ack_o,
    input wire logic counter_read_fault_o,
    input wire logic [1:0] monitor_pin_o,
    input wire logic overflow_irq_o
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_reg_ack; reg_req_i.valid && privilege_zero_i |=> reg_ack_o && !reg_fault_o; endproperty
    property p_reg_fault; reg_req_i.valid && !privilege_zero_i |=> reg_fault_o && !reg_ack_o; endproperty
    property p_reg_idle; !reg_req_i.valid |=> !reg_ack_o && !reg_fault_o; endproperty
    property p_rdata_quiet; !reg_ack_o |-> reg_rdata_o == '0; endproperty
    property p_read_ok; counter_read_i && (!counter_read_gate_i || privilege_zero_i) |=> counter_read_ack_o; endproperty
    property p_read_fault; counter_read_i && counter_read_gate_i && !privilege_zero_i |=> counter_read_fault_o; endproperty
    property p_read_idle; !counter_read_i |=> !counter_read_ack_o && !counter_read_fault_o; endproperty
    property p_pin_width; $rose(monitor_pin_o[0]) |=> monitor_pin_o[0] ##1 !monitor_pin_o[0]; endproperty
    property p_irq_pulse; overflow_irq_o |=> !overflow_irq_o; endproperty
    property p_pin_width_one; $rose(monitor_pin_o[1]) |=> monitor_pin_o[1] ##1 !monitor_pin_o[1]; endproperty

    a_reg_ack: assert property (p_reg_ack) else $error("request not acknowledged");
    a_reg_fault: assert property (p_reg_fault) else $error("request not refused");
    a_reg_idle: assert property (p_reg_idle) else $error("answer without request");
    a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside answer");
    a_read_ok: assert property (p_read_ok) else $error("counter read not answered");
    a_read_fault: assert property (p_read_fault) else $error("counter read not refused");
    a_read_idle: assert property (p_read_idle) else $error("counter read answer unasked");
    a_pin_width: assert property (p_pin_width) else $error("monitor pin width wrong");
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than a pulse");
    a_pin_width_one: assert property (p_pin_width_one) else $error("second monitor pin width wrong");

    c_fault: cover property (reg_fault_o);
    c_irq: cover property (overflow_irq_o);
    c_pin: cover property ($rose(monitor_pin_o[0]));
    c_read_fault: cover property (counter_read_fault_o);
endmodule // dual_event_perf_counters_chk

bind dual_event_perf_counters dual_event_perf_counters_chk #(
    .COUNT_WIDTH(COUNT_WIDTH), .EVENT_COUNT_WIDTH(EVENT_COUNT_WIDTH), .UNIT_COUNT(UNIT_COUNT)
) u_chk (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .privilege_zero_i(privilege_zero_i),
    .counter_read_gate_i(counter_read_gate_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .reg_ack_o(reg_ack_o), .reg_fault_o(reg_fault_o), .counter_read_i(counter_read_i),
    .counter_read_ack_o(counter_read_ack_o), .counter_read_fault_o(counter_read_fault_o),
    .monitor_pin_o(monitor_pin_o), .overflow_irq_o(overflow_irq_o)
);

// [dual_event_perf_counters_bench.sv]
// Self-checking testbench for the dual event performance counters
`timescale 1ns/1ps

module dual_event_perf_counters_bench;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic privilege_zero_i = 1'b1;
    logic counter_read_gate_i = 1'b0;
    logic [15:0] unit_events_i = 16'h0000;
    logic [7:0] unit_qualifier_i = 8'h01;
    perf_counter_pkg::reg_request_type reg_req_i = '0;
    logic [39:0] reg_rdata_o;
    logic reg_ack_o;
    logic reg_fault_o;
    logic counter_read_i = 1'b0;
    logic counter_read_sel_i = 1'b1;
    logic [39:0] counter_read_data_o;
    logic counter_read_ack_o;
    logic counter_read_fault_o;
    logic [1:0] monitor_pin_o;
    logic overflow_irq_o;
    logic [39:0] x;
    logic f;
    logic [1:0] pin_d = 2'h0;
    int err_total = 0;
    int n_tests = 0;
    int irq_cnt = 0;
    int pin_cnt = 0;

    dual_event_perf_counters DUT (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .privilege_zero_i(privilege_zero_i),
        .counter_read_gate_i(counter_read_gate_i), .unit_events_i(unit_events_i),
        .unit_qualifier_i(unit_qualifier_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
        .reg_ack_o(reg_ack_o), .reg_fault_o(reg_fault_o), .counter_read_i(counter_read_i),
        .counter_read_sel_i(counter_read_sel_i), .counter_read_data_o(counter_read_data_o),
        .counter_read_ack_o(counter_read_ack_o), .counter_read_fault_o(counter_read_fault_o),
        .monitor_pin_o(monitor_pin_o), .overflow_irq_o(overflow_irq_o)
    );

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // Counts interrupt pulses and rising edges of either monitor pin
    always @(posedge clk_i) begin
        if (overflow_irq_o === 1'b1) irq_cnt++;
        if (monitor_pin_o[0] === 1'b1 && pin_d[0] !== 1'b1) pin_cnt++;
        if (monitor_pin_o[1] === 1'b1 && pin_d[1] !== 1'b1) pin_cnt++;
        pin_d <= monitor_pin_o;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [1:0] s, input logic [31:0] d);
        @(posedge clk_i);
        #1 reg_req_i = '{1'b1, w, s, d};
        @(posedge clk_i);
        #1 reg_req_i.valid = 1'b0;
        x = reg_rdata_o;
        f = reg_fault_o;
        check({38'h0, reg_ack_o, f}, {38'h0, privilege_zero_i, !privilege_zero_i});
    endtask

    task automatic wr(input logic [1:0] s, input logic [31:0] d);
        xfer(1'b1, s, d);
    endtask

    task automatic rdc(input logic [1:0] s, input logic [39:0] exp);
        xfer(1'b0, s, 32'h0);
        check(x, exp);
    endtask

    // Five cycles of events 1, 3, 5, 7 on units 0 to 3
    task automatic burst(input logic pz);
        @(posedge clk_i);
        #1 irq_cnt = 0;
        pin_cnt = 0;
        privilege_zero_i = pz;
        unit_events_i = 16'h7531;
        repeat (5) @(posedge clk_i);
        #1 unit_events_i = 16'h0000;
        privilege_zero_i = 1'b1;
        repeat (12) @(posedge clk_i);
    endtask

    task automatic run_case(input logic [31:0] cfg, input logic pz, input logic [31:0] pre,
                            input logic [39:0] exp, input logic [1:0] flags);
        wr(perf_counter_pkg::SEL_COUNT_ZERO, pre);
        wr(perf_counter_pkg::SEL_SETUP_ZERO, cfg);
        burst(pz);
        wr(perf_counter_pkg::SEL_SETUP_ZERO, 32'h0);
        rdc(perf_counter_pkg::SEL_COUNT_ZERO, exp);
        check({38'h0, irq_cnt == 1, pin_cnt != 0}, {38'h0, flags});
        $display("case %h done", cfg);
    endtask

    task automatic pmc(input logic g, input logic pz, input logic sel, input logic [39:0] exp, input logic flt);
        @(posedge clk_i);
        #1 counter_read_gate_i = g;
        privilege_zero_i = pz;
        counter_read_sel_i = sel;
        counter_read_i = 1'b1;
        @(posedge clk_i);
        #1 counter_read_i = 1'b0;
        privilege_zero_i = 1'b1;
        check({38'h0, counter_read_ack_o, counter_read_fault_o}, {38'h0, !flt, flt});
        if (!flt) check(counter_read_data_o, exp);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        for (int i = 0; i < 4; i++) rdc(i[1:0], 40'h0);
        wr(perf_counter_pkg::SEL_SETUP_ONE, 32'h0040_0000);
        rdc(perf_counter_pkg::SEL_SETUP_ONE, 40'h0);
        wr(perf_counter_pkg::SEL_SETUP_ZERO, 32'hff00_00ff);
        rdc(perf_counter_pkg::SEL_SETUP_ZERO, 40'hff00_00ff);
        wr(perf_counter_pkg::SEL_COUNT_ZERO, 32'h8000_0001);
        rdc(perf_counter_pkg::SEL_COUNT_ZERO, 40'hff_8000_0001);
        wr(perf_counter_pkg::SEL_COUNT_ONE, 32'h7fff_ffff);
        rdc(perf_counter_pkg::SEL_COUNT_ONE, 40'h00_7fff_ffff);
        privilege_zero_i = 1'b0;
        xfer(1'b1, perf_counter_pkg::SEL_SETUP_ZERO, 32'h0);
        privilege_zero_i = 1'b1;
        rdc(perf_counter_pkg::SEL_SETUP_ZERO, 40'hff00_00ff);
        $display("register test done");
        run_case(32'h0043_0001, 1'b1, 32'h0, 40'h0f, 2'b00);
        run_case(32'h0043_0003, 1'b1, 32'h0, 40'h23, 2'b00);
        run_case(32'h0003_0001, 1'b1, 32'h0, 40'h00, 2'b00);
        run_case(32'h0042_0001, 1'b0, 32'h0, 40'h00, 2'b00);
        run_case(32'h0042_0001, 1'b1, 32'h0, 40'h0f, 2'b00);
        run_case(32'h0041_0001, 1'b0, 32'h0, 40'h0f, 2'b00);
        run_case(32'h0041_0001, 1'b1, 32'h0, 40'h00, 2'b00);
        run_case(32'h0047_0001, 1'b1, 32'h0, 40'h01, 2'b00);
        run_case(32'h0343_0001, 1'b1, 32'h0, 40'h05, 2'b00);
        run_case(32'h0443_0001, 1'b1, 32'h0, 40'h00, 2'b00);
        run_case(32'h04c1_0001, 1'b0, 32'h0, 40'h05, 2'b00);
        run_case(32'h02c1_0001, 1'b0, 32'h0, 40'h00, 2'b00);
        run_case(32'h00c3_0001, 1'b1, 32'h0, 40'h0f, 2'b00);
        run_case(32'h0043_0201, 1'b1, 32'h0, 40'h00, 2'b00);
        run_case(32'h0043_0101, 1'b1, 32'h0, 40'h0f, 2'b00);
        run_case(32'h0053_0000, 1'b1, 32'hffff_fffe, 40'h03, 2'b11);
        run_case(32'h0043_0000, 1'b1, 32'hffff_fffe, 40'h03, 2'b01);
        run_case(32'h004b_0000, 1'b1, 32'h0, 40'h05, 2'b01);
        wr(perf_counter_pkg::SEL_COUNT_ONE, 32'h0);
        wr(perf_counter_pkg::SEL_SETUP_ONE, 32'h000b_0002);
        wr(perf_counter_pkg::SEL_SETUP_ZERO, 32'h0040_0000);
        burst(1'b1);
        rdc(perf_counter_pkg::SEL_COUNT_ONE, 40'h19);
        check({39'h0, pin_cnt != 0}, 40'h1);
        wr(perf_counter_pkg::SEL_SETUP_ONE, 32'h0);
        burst(1'b1);
        rdc(perf_counter_pkg::SEL_COUNT_ONE, 40'h19);
        check({39'h0, pin_cnt != 0}, 40'h0);
        wr(perf_counter_pkg::SEL_SETUP_ONE, 32'h000b_0002);
        wr(perf_counter_pkg::SEL_SETUP_ZERO, 32'h0);
        burst(1'b1);
        rdc(perf_counter_pkg::SEL_COUNT_ONE, 40'h19);
        check({39'h0, pin_cnt != 0}, 40'h0);
        $display("second counter test done");
        pmc(1'b1, 1'b0, 1'b1, 40'h19, 1'b1);
        pmc(1'b0, 1'b0, 1'b1, 40'h19, 1'b0);
        pmc(1'b1, 1'b1, 1'b1, 40'h19, 1'b0);
        pmc(1'b0, 1'b0, 1'b0, 40'h05, 1'b0);
        $display("counter read test done");
        tally_and_finish();
    end
endmodule // dual_event_perf_counters_bench
